/* File: design/dtr_pkg.sv */
// Package: constants and carrier types for the tone-pair receive steering
package dtr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned DTR_CLK_HZ = 50_000_000;
    localparam int unsigned DTR_CLK_MHZ = DTR_CLK_HZ / 1_000_000;
    localparam int unsigned DTR_GTP_US = 20_000;   // Tone present guard
    localparam int unsigned DTR_GTA_US = 20_000;   // Tone absent guard
    localparam int unsigned DTR_GTP_CYCLES = DTR_GTP_US * DTR_CLK_MHZ;
    localparam int unsigned DTR_GTA_CYCLES = DTR_GTA_US * DTR_CLK_MHZ;
    localparam int unsigned DTR_SETTLE_NS = 80;     // Output latch settling
    localparam int unsigned DTR_SETTLE_CYCLES =
        (DTR_SETTLE_NS * DTR_CLK_MHZ + 999) / 1000;
    localparam int unsigned DTR_GUARD_W = 24;

    // ------------------------------------------------------------
    // Tone measurement
    // ------------------------------------------------------------
    localparam int unsigned DTR_LOW_HZ [4] = '{697, 770, 852, 941};
    localparam int unsigned DTR_HIGH_HZ [4] = '{1209, 1336, 1477, 1633};
    localparam int unsigned DTR_TOL_PCT = 3;        // Accepted deviation
    localparam int unsigned DTR_PER_W = 18;
    localparam logic [DTR_PER_W-1:0] DTR_PER_TIMEOUT = 18'h12100;
    localparam logic [1:0] DTR_CONFIRM = 2'h2;      // Matching periods

    // Code of each pair, indexed by {low index, high index}
    localparam logic [3:0] DTR_CODE_MAP [16] = '{
        4'h1, 4'h2, 4'h3, 4'hD,
        4'h4, 4'h5, 4'h6, 4'hE,
        4'h7, 4'h8, 4'h9, 4'hF,
        4'hB, 4'hA, 4'hC, 4'h0};

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DTR_RX_DATA_OFS = 8'h00;
    localparam logic [7:0] DTR_STATUS_OFS = 8'h04;
    localparam logic [7:0] DTR_CONTROL_OFS = 8'h08;
    localparam logic [7:0] DTR_GUARD_PRESENT_OFS = 8'h0C;
    localparam logic [7:0] DTR_GUARD_ABSENT_OFS = 8'h10;
    localparam logic [7:0] DTR_INT_STATUS_OFS = 8'h14;
    localparam logic [7:0] DTR_INT_CLEAR_OFS = 8'h18;
    localparam logic [7:0] DTR_INT_ENABLE_OFS = 8'h1C;

    // Field positions
    localparam int unsigned DTR_ST_IRQ_BIT = 0;
    localparam int unsigned DTR_ST_EARLY_BIT = 1;
    localparam int unsigned DTR_ST_READY_BIT = 2;
    localparam int unsigned DTR_ST_DELAYED_BIT = 3;
    localparam int unsigned DTR_CTL_IRQ_MODE_BIT = 0;
    localparam int unsigned DTR_CTL_CP_MODE_BIT = 1;
    localparam int unsigned DTR_EV_DATA_BIT = 0;
    localparam int unsigned DTR_EV_PAUSE_BIT = 1;
    localparam int unsigned DTR_EV_W = 2;

    // Reset values
    localparam logic [1:0] DTR_CONTROL_RST = 2'h0;
    localparam logic [DTR_EV_W-1:0] DTR_INT_ENABLE_RST = 2'h0;

    // ------------------------------------------------------------
    // APB carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } dtr_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dtr_apb_rsp_type;

    typedef enum logic [1:0] {
        DTR_WAIT_TONE = 2'b01,
        DTR_REGISTERED = 2'b10
    } dtr_steer_state_type;

endpackage

/* File: design/dtr_steering.sv */
// Module: tone-pair verify, steering, guard timing and APB register file
//
// Function
// - Sixteen tone pairs encode to 4-bit codes; D is zero, 0 is ten.
// - Tone periods are counted and accepted only near standard frequencies.
// - early_steer rises once both groups hold a valid tone.
// - Any loss of the valid pair drops early_steer at once.
// - Rising steer_sense registers the present pair into the latch.
// - Falling steer_sense re-arms the receiver for a new pair.
// - guard_drive is high while registered and early_steer both hold.
// - Registration stores the pair's 4-bit code.
// - Delayed steering flag rises a short settle time after latching.
// - Delayed steering flag is readable as a status bit.
// - In interrupt mode irq_or_tone_out is pulled low on new data.
// - Receive data updates only when the delayed flag activates.
// - Reading receive data returns the latched code on the data lanes.
// - Short tone dropouts under the absent guard leave data unchanged.
// - Status b2 marks valid data and clears after a status read.
// - Interrupt asserts on new data and clears on status read.
// - Call progress mode suppresses tone-pair detection.
`timescale 1ns/10ps
`default_nettype none
module dtr_steering #(
    parameter int unsigned GTP_CYCLES = dtr_pkg::DTR_GTP_CYCLES,
    parameter int unsigned GTA_CYCLES = dtr_pkg::DTR_GTA_CYCLES,
    parameter int unsigned CLK_HZ = dtr_pkg::DTR_CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic low_tone_in,
    input wire logic high_tone_in,
    input wire dtr_pkg::dtr_apb_req_type apb_req,
    output dtr_pkg::dtr_apb_rsp_type apb_rsp,
    output logic early_steer,
    output logic steer_sense,
    output logic guard_drive,
    output logic delayed_steer,
    output logic irq_or_tone_out,
    output logic irq
);
    import dtr_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [DTR_GUARD_W-1:0] GTP_RST = DTR_GUARD_W'(GTP_CYCLES);
    localparam logic [DTR_GUARD_W-1:0] GTA_RST = DTR_GUARD_W'(GTA_CYCLES);
    localparam logic [3:0] SETTLE_LD = 4'(DTR_SETTLE_CYCLES);
    // Period timeout scaled to the clock rate in use
    localparam logic [DTR_PER_W-1:0] PER_TMO =
        DTR_PER_W'(longint'(DTR_PER_TIMEOUT) * CLK_HZ / DTR_CLK_HZ);

    logic [1:0] tone_in;
    logic [1:0] grp_valid;
    logic [1:0] grp_idx [2];
    logic [3:0] cur_code_ff;
    logic early_steer_ff;
    logic guard_drive_ff;
    dtr_steer_state_type state_ff;
    logic [DTR_GUARD_W-1:0] guard_cnt_ff;
    logic [DTR_GUARD_W-1:0] gtp_ff;
    logic [DTR_GUARD_W-1:0] gta_ff;
    logic [3:0] code_latch_ff;
    logic [3:0] settle_ff;
    logic delayed_steer_ff;
    logic [3:0] rx_data_ff;
    logic rx_ready_ff;
    logic [1:0] control_ff;
    logic [DTR_EV_W-1:0] int_status_ff;
    logic [DTR_EV_W-1:0] int_enable_ff;
    logic irq_ff;
    logic pin_ff;
    dtr_apb_rsp_type apb_rsp_ff;
    logic setup;
    logic access;
    logic status_rd;
    logic data_event;
    logic pause_event;
    logic cp_mode;
    logic irq_mode;

    assign tone_in = {high_tone_in, low_tone_in};
    assign cp_mode = control_ff[DTR_CTL_CP_MODE_BIT];
    assign irq_mode = control_ff[DTR_CTL_IRQ_MODE_BIT];

    // ------------------------------------------------------------
    // Tone period classification
    // ------------------------------------------------------------
    // Returns {match, index} for a measured period of one group
    function automatic logic [2:0] classify(input logic grp,
                                            input logic [DTR_PER_W-1:0] c);
        int unsigned hz;
        int unsigned per;
        int unsigned lo;
        int unsigned hi;
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < 4; k++) begin
            hz = grp ? DTR_HIGH_HZ[k] : DTR_LOW_HZ[k];
            per = CLK_HZ / hz;
            lo = per * (100 - DTR_TOL_PCT) / 100;
            hi = per * (100 + DTR_TOL_PCT) / 100;
            if (32'(c) >= lo && 32'(c) <= hi) begin
                r = {1'b1, 2'(k)};
            end
        end
        return r;
    endfunction

    // One period meter per tone group
    for (genvar g = 0; g < 2; g++) begin : grp
        logic prev_ff;
        logic [DTR_PER_W-1:0] per_cnt_ff;
        logic [1:0] idx_ff;
        logic [1:0] hits_ff;
        logic [2:0] cls;

        assign cls = classify(1'(g), per_cnt_ff);
        assign grp_valid[g] = (hits_ff >= DTR_CONFIRM);
        assign grp_idx[g] = idx_ff;

        // Count cycles between rising edges, confirm repeated matches
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                prev_ff <= 1'b0;
                per_cnt_ff <= '0;
                idx_ff <= 2'h0;
                hits_ff <= 2'h0;
            end else begin
                prev_ff <= tone_in[g];
                if (tone_in[g] && !prev_ff) begin
                    per_cnt_ff <= '0;
                    if (cls[2]) begin
                        idx_ff <= cls[1:0];
                        if (cls[1:0] != idx_ff || hits_ff == 2'h0) begin
                            hits_ff <= 2'h1;
                        end else if (hits_ff != 2'h3) begin
                            hits_ff <= hits_ff + 2'h1;
                        end
                    end else begin
                        hits_ff <= 2'h0;
                    end
                end else if (per_cnt_ff == PER_TMO) begin
                    hits_ff <= 2'h0; // Tone gone
                end else begin
                    per_cnt_ff <= per_cnt_ff + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Early steering and current code
    // ------------------------------------------------------------
    // Signal condition: both groups valid, not in call progress mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            early_steer_ff <= 1'b0;
            cur_code_ff <= 4'h0;
        end else begin
            early_steer_ff <= grp_valid[0] && grp_valid[1] && !cp_mode;
            cur_code_ff <= DTR_CODE_MAP[{grp_idx[0], grp_idx[1]}];
        end
    end

    // ------------------------------------------------------------
    // Steering: guard counters standing in for the RC network
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= DTR_WAIT_TONE;
            guard_cnt_ff <= '0;
            code_latch_ff <= 4'h0;
        end else begin
            unique case (state_ff)
                DTR_WAIT_TONE: begin
                    if (!early_steer_ff) begin
                        guard_cnt_ff <= '0;
                    end else if (guard_cnt_ff + 1'b1 >= gtp_ff) begin
                        state_ff <= DTR_REGISTERED;
                        guard_cnt_ff <= '0;
                        code_latch_ff <= cur_code_ff;
                    end else begin
                        guard_cnt_ff <= guard_cnt_ff + 1'b1;
                    end
                end
                DTR_REGISTERED: begin
                    if (early_steer_ff) begin
                        guard_cnt_ff <= '0;
                    end else if (guard_cnt_ff + 1'b1 >= gta_ff) begin
                        state_ff <= DTR_WAIT_TONE;
                        guard_cnt_ff <= '0;
                    end else begin
                        guard_cnt_ff <= guard_cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= DTR_WAIT_TONE;
                    guard_cnt_ff <= '0;
                end
            endcase
        end
    end

    assign steer_sense = state_ff[1]; // One-hot bit of registered state
    assign pause_event = (state_ff == DTR_REGISTERED) && !early_steer_ff
        && (guard_cnt_ff + 1'b1 >= gta_ff);

    // Guard drive follows the sense while the tone stays
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            guard_drive_ff <= 1'b0;
        end else begin
            guard_drive_ff <= steer_sense && early_steer_ff;
        end
    end

    // ------------------------------------------------------------
    // Settling delay, delayed steering and receive data
    // ------------------------------------------------------------
    assign data_event = (settle_ff == 4'h1) && steer_sense;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            settle_ff <= 4'h0;
            delayed_steer_ff <= 1'b0;
            rx_data_ff <= 4'h0;
        end else if (!steer_sense) begin
            settle_ff <= 4'h0;
            delayed_steer_ff <= 1'b0;
        end else if (!delayed_steer_ff && settle_ff == 4'h0) begin
            settle_ff <= SETTLE_LD;
        end else if (data_event) begin
            settle_ff <= 4'h0;
            delayed_steer_ff <= 1'b1;
            rx_data_ff <= code_latch_ff;
        end else if (settle_ff != 4'h0) begin
            settle_ff <= settle_ff - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && apb_rsp_ff.pready;
    assign status_rd = access && !apb_req.pwrite
        && apb_req.paddr == DTR_STATUS_OFS;

    // Read multiplexer, returns {error, data}
    function automatic logic [32:0] read_reg(input logic [7:0] a);
        logic [32:0] r;
        r = '0;
        unique case (a)
            DTR_RX_DATA_OFS: r[3:0] = rx_data_ff;
            DTR_STATUS_OFS: begin
                r[DTR_ST_IRQ_BIT] = irq_ff;
                r[DTR_ST_EARLY_BIT] = early_steer_ff;
                r[DTR_ST_READY_BIT] = rx_ready_ff;
                r[DTR_ST_DELAYED_BIT] = delayed_steer_ff;
            end
            DTR_CONTROL_OFS: r[1:0] = control_ff;
            DTR_GUARD_PRESENT_OFS: r[DTR_GUARD_W-1:0] = gtp_ff;
            DTR_GUARD_ABSENT_OFS: r[DTR_GUARD_W-1:0] = gta_ff;
            DTR_INT_STATUS_OFS: r[DTR_EV_W-1:0] = int_status_ff;
            DTR_INT_CLEAR_OFS: r = '0;
            DTR_INT_ENABLE_OFS: r[DTR_EV_W-1:0] = int_enable_ff;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // Answer registered in setup, ready in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            apb_rsp_ff <= '0;
        end else begin
            apb_rsp_ff.pready <= setup;
            if (setup) begin
                {apb_rsp_ff.pslverr, apb_rsp_ff.prdata} <=
                    read_reg(apb_req.paddr);
            end
        end
    end

    // Writable configuration
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            control_ff <= DTR_CONTROL_RST;
            gtp_ff <= GTP_RST;
            gta_ff <= GTA_RST;
            int_enable_ff <= DTR_INT_ENABLE_RST;
        end else if (access && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                DTR_CONTROL_OFS: control_ff <= apb_req.pwdata[1:0];
                DTR_GUARD_PRESENT_OFS:
                    gtp_ff <= apb_req.pwdata[DTR_GUARD_W-1:0];
                DTR_GUARD_ABSENT_OFS:
                    gta_ff <= apb_req.pwdata[DTR_GUARD_W-1:0];
                DTR_INT_ENABLE_OFS:
                    int_enable_ff <= apb_req.pwdata[DTR_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Ready flag and interrupt events (set wins over clear)
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_ready_ff <= 1'b0;
        end else if (data_event) begin
            rx_ready_ff <= 1'b1;
        end else if (status_rd) begin
            rx_ready_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_status_ff <= '0;
        end else begin
            for (int b = 0; b < DTR_EV_W; b++) begin
                if ((b == DTR_EV_DATA_BIT && data_event)
                    || (b == DTR_EV_PAUSE_BIT && pause_event)) begin
                    int_status_ff[b] <= 1'b1;
                end else if ((access && apb_req.pwrite
                    && apb_req.paddr == DTR_INT_CLEAR_OFS
                    && apb_req.pwdata[b])
                    || (status_rd && b == DTR_EV_DATA_BIT)) begin
                    int_status_ff[b] <= 1'b0;
                end
            end
        end
    end

    // Interrupt output and the shared pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
            pin_ff <= 1'b1;
        end else begin
            irq_ff <= |(int_status_ff & int_enable_ff);
            if (cp_mode) begin
                pin_ff <= low_tone_in; // Squared input in call progress
            end else begin
                pin_ff <= !(irq_mode && rx_ready_ff);
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign early_steer = early_steer_ff;
    assign guard_drive = guard_drive_ff;
    assign delayed_steer = delayed_steer_ff;
    assign irq_or_tone_out = pin_ff;
    assign irq = irq_ff;
    assign apb_rsp = apb_rsp_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_registered;
        $rose(steer_sense);
    endsequence

    a_cp_blocks_steer: assert property (@(posedge sys_clk) disable iff (reset)
        cp_mode |=> !early_steer_ff)
        else $error("early steer high in call progress mode");
    a_steer_loss_drop: assert property (@(posedge sys_clk) disable iff (reset)
        !(grp_valid[0] && grp_valid[1]) |=> !early_steer_ff)
        else $error("early steer kept after loss of pair");
    a_steer_rise: assert property (@(posedge sys_clk) disable iff (reset)
        grp_valid[0] && grp_valid[1] && !cp_mode |=> early_steer_ff)
        else $error("early steer missing for valid pair");
    a_guard_follows: assert property (@(posedge sys_clk) disable iff (reset)
        steer_sense && early_steer_ff |=> guard_drive_ff)
        else $error("guard drive not following steer");
    a_code_latched: assert property (@(posedge sys_clk) disable iff (reset)
        s_registered |-> code_latch_ff == $past(cur_code_ff))
        else $error("registered code differs from detected pair");
    a_settle_delay: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(delayed_steer_ff) |-> $past(steer_sense, 4))
        else $error("delayed steer rose before settle time");
    a_latch_on_flag: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(rx_data_ff) |-> $rose(delayed_steer_ff))
        else $error("receive data changed without delayed steer");
    a_rearm_on_fall: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(steer_sense) |-> !$past(early_steer_ff))
        else $error("steer sense fell while tone present");
    a_irq_pin_low: assert property (@(posedge sys_clk) disable iff (reset)
        irq_mode && !cp_mode && rx_ready_ff |=> !irq_or_tone_out)
        else $error("interrupt pin not pulled low");
    a_ready_clear: assert property (@(posedge sys_clk) disable iff (reset)
        status_rd && !data_event |=> !rx_ready_ff)
        else $error("ready bit not cleared by status read");
    a_rx_read_data: assert property (@(posedge sys_clk) disable iff (reset)
        setup && apb_req.paddr == DTR_RX_DATA_OFS
        |=> apb_rsp_ff.prdata[3:0] == $past(rx_data_ff))
        else $error("receive data read returned wrong code");

endmodule
`default_nettype wire

/* File: test/dtr_host_model.sv */
// Host model: APB master that reads and writes the receiver registers
`timescale 1ns/10ps
`default_nettype none
module dtr_host_model (
    input wire logic sys_clk,
    output dtr_pkg::dtr_apb_req_type apb_req,
    input wire dtr_pkg::dtr_apb_rsp_type apb_rsp
);
    import dtr_pkg::*;

    initial apb_req = '0;

    // ----------------------------------------
    // One transfer: setup, access, wait ready
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge sys_clk);
        apb_req.paddr <= addr;
        apb_req.pwrite <= wr;
        apb_req.pwdata <= wdata;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        @(posedge sys_clk);
        while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test/dtr_receive_steering_tb.sv */
// Testbench: tone pair registration, status, interrupt and mode checks
`timescale 1ns/10ps
`default_nettype none
module dtr_receive_steering_tb;
    import dtr_pkg::*;
    logic sys_clk, reset, err, l, early_steer, steer_sense, guard_drive;
    logic low_tone_in = 1'b0;
    logic high_tone_in = 1'b0;
    logic delayed_steer, irq_or_tone_out, irq;
    logic [31:0] rd;
    dtr_apb_req_type apb_req;
    dtr_apb_rsp_type apb_rsp;
    int error_cnt = 0, compares = 0, cyc = 0, n;
    int lo_half = 0, hi_half = 0, lo_cnt = 0, hi_cnt = 0;

    // Tone periods scaled as for a 5 MHz clock to keep the run short
    dtr_steering #(.GTP_CYCLES(20), .GTA_CYCLES(20),
        .CLK_HZ(5_000_000)) dtr_steering_inst (
        .sys_clk(sys_clk), .reset(reset), .low_tone_in(low_tone_in),
        .high_tone_in(high_tone_in), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .early_steer(early_steer), .steer_sense(steer_sense),
        .guard_drive(guard_drive), .delayed_steer(delayed_steer),
        .irq_or_tone_out(irq_or_tone_out), .irq(irq));
    dtr_host_model dtr_host_model_inst (
        .sys_clk(sys_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    // ----------------------------------------
    // Clock, timeout, tone square waves
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // Half period zero holds the line low
    always @(posedge sys_clk) begin
        if (lo_half == 0) begin
            low_tone_in <= 1'b0;
            lo_cnt <= 0;
        end else if (lo_cnt >= lo_half - 1) begin
            low_tone_in <= ~low_tone_in;
            lo_cnt <= 0;
        end else lo_cnt <= lo_cnt + 1;
    end
    always @(posedge sys_clk) begin
        if (hi_half == 0) begin
            high_tone_in <= 1'b0;
            hi_cnt <= 0;
        end else if (hi_cnt >= hi_half - 1) begin
            high_tone_in <= ~high_tone_in;
            hi_cnt <= 0;
        end else hi_cnt <= hi_cnt + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        dtr_host_model_inst.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dtr_host_model_inst.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic give_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(DTR_CONTROL_OFS, 32'h0);
        rd_chk(DTR_STATUS_OFS, 32'h0);
        rd_chk(DTR_INT_ENABLE_OFS, 32'h0);
        check(irq_or_tone_out, 1'b1);
        rd_chk(8'h20, 32'h0);
        check(err, 1'b1);
        $display("test reset done");
        wr(DTR_GUARD_PRESENT_OFS, 32'h14);
        wr(DTR_GUARD_ABSENT_OFS, 32'h14);
        rd_chk(DTR_GUARD_PRESENT_OFS, 32'h14);
        wr(DTR_CONTROL_OFS, 32'h1);
        wr(DTR_INT_ENABLE_OFS, 32'h1);
        // Hash key: low and high group square waves
        lo_half <= 2657;
        hi_half <= 1693;
        for (n = 0; n < 20000 && early_steer !== 1'b1; n++)
            @(posedge sys_clk);
        check(early_steer, 1'b1);
        check(delayed_steer, 1'b0);
        for (n = 0; n < 100 && delayed_steer !== 1'b1; n++)
            @(posedge sys_clk);
        check(steer_sense & guard_drive, 1'b1);
        rd_chk(DTR_RX_DATA_OFS, 32'hC);
        check(irq, 1'b1);
        check(irq_or_tone_out, 1'b0);
        rd_chk(DTR_STATUS_OFS, 32'hF);
        rd_chk(DTR_STATUS_OFS, 32'hA);
        check(irq, 1'b0);
        check(irq_or_tone_out, 1'b1);
        $display("test registration done");
        // Tone ends: early flag drops, then the pause guard runs
        lo_half <= 0;
        hi_half <= 0;
        for (n = 0; n < 10000 && early_steer !== 1'b0; n++)
            @(posedge sys_clk);
        check(early_steer, 1'b0);
        for (n = 0; n < 100 && steer_sense !== 1'b0; n++)
            @(posedge sys_clk);
        check(steer_sense, 1'b0);
        repeat (3) @(posedge sys_clk);
        check(delayed_steer, 1'b0);
        rd_chk(DTR_RX_DATA_OFS, 32'hC);
        rd_chk(DTR_INT_STATUS_OFS, 32'h2);
        wr(DTR_INT_CLEAR_OFS, 32'h2);
        rd_chk(DTR_INT_STATUS_OFS, 32'h0);
        $display("test pause done");
        // Call progress mode: pin follows low group input
        wr(DTR_CONTROL_OFS, 32'h2);
        lo_half <= 5;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            l = low_tone_in;
            @(negedge sys_clk);
            check(irq_or_tone_out, l);
        end
        // Valid pair in call progress mode must not register
        @(posedge sys_clk);
        lo_half <= 2657;
        hi_half <= 1693;
        repeat (16000) @(posedge sys_clk);
        check(early_steer, 1'b0);
        check(delayed_steer, 1'b0);
        $display("test call progress done");
        give_verdict();
    end
endmodule
`default_nettype wire
